// File: shared/dhb_map.vh
// Port addresses, register indices, field positions and reset values of the host bus block
`ifndef DHB_MAP_VH
`define DHB_MAP_VH
`define DHB_IO_PAL_FIRST 16'h03C6
`define DHB_IO_PAL_LAST 16'h03C9
`define DHB_IO_PAL_STATE 16'h03C7
`define DHB_IO_ATTR 16'h03C0
`define DHB_IO_ATTR_RD 16'h03C1
`define DHB_IO_SEQ_IDX 16'h03C4
`define DHB_IO_SEQ_DAT 16'h03C5
`define DHB_IO_CRT_IDX 16'h03D4
`define DHB_IO_CRT_DAT 16'h03D5
`define DHB_IO_EXT_IDX 16'h03D6
`define DHB_IO_EXT_DAT 16'h03D7
`define DHB_IO_SETUP_PORT 16'h46E8
`define DHB_IO_CFG_FIRST 16'h0100
`define DHB_IO_CFG_LAST 16'h0104
`define DHB_IO_CFG_ID0 16'h0100
`define DHB_IO_CFG_ID1 16'h0101
`define DHB_IO_CFG_ENABLE 16'h0102
`define DHB_SEQ_CLK_MODE 8'h01
`define DHB_CRT_CAPT_HI 8'h10
`define DHB_CRT_CAPT_LO 8'h11
`define DHB_EXT_SWITCH 8'h01
`define DHB_EXT_GP_A 8'h08
`define DHB_EXT_GP_B 8'h09
`define DHB_EXT_EMUL 8'h14
`define DHB_EXT_WPROT 8'h15
`define DHB_EXT_TRAP_EN 8'h16
`define DHB_EXT_TRAP_ST 8'h17
`define DHB_EXT_DEF_VID 8'h2B
`define DHB_SEQ_BLANK_BIT 5
`define DHB_SETUP_BIT 4
`define DHB_ENABLE_BIT 0
`define DHB_EMU_FRAME_EN 0
`define DHB_EMU_FRAME_CLR 1
`define DHB_EMU_PANEL_LUT 4
`define DHB_EMU_WIDE_MEM 5
`define DHB_EMU_FAST_OFF 6
`define DHB_EMU_IRQ_MODE 7
`define DHB_WP_SEQ 0
`define DHB_WP_ATTR 1
`define DHB_WP_CRT 2
`define DHB_GP_NORMAL 2'h0
`define DHB_GP_FLOAT 2'h1
`define DHB_GP_LOW 2'h2
`define DHB_GP_HIGH 2'h3
`define DHB_MEM_WIN 3'h1
`define DHB_ROM_WIN 3'h4
`define DHB_RST_BYTE 8'h00
`define DHB_RST_LUT 6'h00
`define DHB_LUT_DEPTH 16
`define DHB_LUT_W 6
`endif

// File: logic/dhb_switch_sample.v
// Switch input register: samples the seven multiplexed switch lines on a CPU read
`timescale 1ns/10ps
`include "dhb_map.vh"
module dhb_switch_sample (
	input wire mclk,
	input wire nrst,
	input wire ce,
	input wire sample,
	input wire [2:0] a_upper,
	input wire bhe_n,
	input wire high_address_decode_in,
	input wire aen_mio,
	input wire rfsh_enab,
	output reg [7:0] switch_q
);
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			switch_q <= `DHB_RST_BYTE;
		end else if (ce && sample) begin
			// Bit 7 has no switch behind it and reads zero
			switch_q <= {1'b0, rfsh_enab, aen_mio, high_address_decode_in, bhe_n, a_upper};
		end
	end
endmodule

// File: logic/dhb_host_bus.v
// Host bus interface and system functions of the display controller
`timescale 1ns/10ps
`include "dhb_map.vh"
module dhb_host_bus #(
	parameter [7:0] ID_LOW = 8'h5A,
	parameter [7:0] ID_HIGH = 8'hA5,
	parameter TRAP_W = 8
) (
	input wire mclk,
	input wire nrst,
	input wire ce,
	input wire mca_mode,
	input wire [15:0] ad_in,
	input wire [2:0] a_upper,
	input wire bhe_n,
	input wire high_address_decode_in,
	input wire aen_mio,
	input wire memw_n,
	input wire memr_n,
	input wire iowr_n,
	input wire iord_n,
	input wire rfsh_enab,
	input wire power_down_pin_one,
	output reg [7:0] data_out,
	output reg data_oe_n,
	output reg address_phase_enable_n,
	output reg wide_io_fast_out,
	output reg wide_io_fast_oe_n,
	output reg ready_out,
	output reg ready_oe_n,
	output reg wide_memory_enable_n,
	output reg setup_card_select_n,
	output reg bios_rom_select_n,
	output reg palette_read_strobe_n,
	output reg palette_write_strobe_n,
	output reg irq_out,
	output reg irq_oe_n,
	output reg trap_pin_out,
	output reg trap_pin_oe_n,
	output reg spare_output_b,
	output reg spare_output_b_oe_n,
	input wire spare_normal_b,
	input wire mem_busy,
	input wire vsync,
	input wire frame_end,
	input wire legacy_mode,
	input wire [15:0] display_addr,
	input wire [TRAP_W-1:0] trap_cond,
	input wire blank_n,
	input wire [3:0] pixel_index,
	input wire panel_mode,
	input wire analog_crt,
	output reg [5:0] video_q,
	output reg screen_blank_q,
	output wire use_ext_palette
);
	reg [15:0] ad_s1, ad_s2, ad_q;
	reg [2:0] au_s1, au_s2, au_q;
	reg [8:0] pin_s1, pin_s2;
	reg bhe_q, high_address_decode_in_q, aen_q, cmd_q;
	reg [7:0] seq_idx_q, seq_clk_q, crt_idx_q, ext_idx_q;
	reg [7:0] gp_a_q, gp_b_q, emul_q, wprot_q, def_vid_q, setup_port_q, enable_q;
	reg [TRAP_W-1:0] trap_en_q, trap_st_q;
	reg [15:0] capt_q;
	reg [5:0] lut_q [0:`DHB_LUT_DEPTH-1];
	reg [3:0] attr_idx_q;
	reg attr_data_q, vsync_q, frame_pend_q, hit_q, io_q, wr_q, sw_q;
	wire [7:0] switch_q;
	integer i;

	// Synchronised pin levels
	wire s_bhe_n = pin_s2[0];
	wire s_high_address_decode_in = pin_s2[1];
	wire s_aen = pin_s2[2];
	wire s_memw_n = pin_s2[3];
	wire s_memr_n = pin_s2[4];
	wire s_iowr_n = pin_s2[5];
	wire s_iord_n = pin_s2[6];
	wire s_rfsh = pin_s2[7];
	wire s_pwrdn = pin_s2[8];

	// Returns {output enable low active, level} for one general-purpose pin
	function [1:0] gp_drive;
		input [1:0] cfg;
		input normal;
		begin
			case (cfg)
				`DHB_GP_FLOAT: gp_drive = 2'b10;
				`DHB_GP_LOW: gp_drive = 2'b00;
				`DHB_GP_HIGH: gp_drive = 2'b01;
				default: gp_drive = {1'b0, normal};
			endcase
		end
	endfunction

	function in_range;
		input [15:0] a;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	// Command activity, type and decode, all from synchronised levels
	wire pc_active = ~s_memw_n | ~s_memr_n | ~s_iowr_n | ~s_iord_n;
	wire active = mca_mode ? ~s_iord_n : pc_active;
	wire is_write = mca_mode ? ~s_memw_n : (~s_memw_n | ~s_iowr_n);
	wire is_io = mca_mode ? ~aen_q : (~s_iowr_n | ~s_iord_n);
	wire mca_setup = mca_mode & ~s_iowr_n;
	wire setup_mode = mca_mode ? mca_setup : setup_port_q[`DHB_SETUP_BIT];
	wire card_on = enable_q[`DHB_ENABLE_BIT];
	wire cfg_hit = in_range(ad_q, `DHB_IO_CFG_FIRST, `DHB_IO_CFG_LAST);
	wire io_valid = mca_mode ? s_rfsh : ~aen_q;
	wire mem_valid = s_rfsh & high_address_decode_in_q;
	wire [2:0] mem_win_code = `DHB_MEM_WIN;
	wire mem_win = (au_q[2:1] == mem_win_code[1:0]);
	wire rom_win = (au_q == `DHB_ROM_WIN) & ~ad_q[15];
	wire pal_hit = in_range(ad_q, `DHB_IO_PAL_FIRST, `DHB_IO_PAL_LAST);
	// Setup mode shuts off everything except the configuration ports
	wire io_hit = is_io & io_valid &
		(setup_mode ? cfg_hit : (card_on & ~cfg_hit));
	wire mem_hit = ~is_io & mem_valid & mem_win & card_on & ~setup_mode;
	wire setup_wr = ~mca_mode & ~s_iowr_n & ~aen_q & (ad_q == `DHB_IO_SETUP_PORT);
	wire start = active & ~cmd_q;
	wire io_wr = start & io_hit & is_write;
	wire io_rd = start & io_hit & ~is_write;
	wire sw_read = io_rd & (ad_q == `DHB_IO_EXT_DAT) & (ext_idx_q == `DHB_EXT_SWITCH);
	wire [7:0] wdat = ad_s2[7:0];
	assign use_ext_palette = analog_crt & ~panel_mode;

	dhb_switch_sample u_switch (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.sample(sw_read),
		.a_upper(au_s2),
		.bhe_n(s_bhe_n),
		.high_address_decode_in(s_high_address_decode_in),
		.aen_mio(s_aen),
		.rfsh_enab(s_rfsh),
		.switch_q(switch_q)
	);

	// Read mux; a switch read is corrected one edge later from the sampled register
	reg [7:0] rd_d;
	always @* begin
		rd_d = `DHB_RST_BYTE;
		if (ad_q == `DHB_IO_CFG_ID0) begin
			rd_d = ID_LOW;
		end else if (ad_q == `DHB_IO_CFG_ID1) begin
			rd_d = ID_HIGH;
		end else if (ad_q == `DHB_IO_CFG_ENABLE) begin
			rd_d = enable_q;
		end else if (ad_q == `DHB_IO_SEQ_IDX) begin
			rd_d = seq_idx_q;
		end else if (ad_q == `DHB_IO_SEQ_DAT) begin
			rd_d = (seq_idx_q == `DHB_SEQ_CLK_MODE) ? seq_clk_q : `DHB_RST_BYTE;
		end else if (ad_q == `DHB_IO_CRT_IDX) begin
			rd_d = crt_idx_q;
		end else if (ad_q == `DHB_IO_CRT_DAT) begin
			if (crt_idx_q == `DHB_CRT_CAPT_HI)
				rd_d = capt_q[15:8];
			else if (crt_idx_q == `DHB_CRT_CAPT_LO)
				rd_d = capt_q[7:0];
		end else if (ad_q == `DHB_IO_ATTR_RD) begin
			rd_d = {2'b00, lut_q[attr_idx_q]};
		end else if (ad_q == `DHB_IO_EXT_IDX) begin
			rd_d = ext_idx_q;
		end else if (ad_q == `DHB_IO_EXT_DAT) begin
			if (ext_idx_q == `DHB_EXT_SWITCH)
				rd_d = switch_q;
			else if (ext_idx_q == `DHB_EXT_GP_A)
				rd_d = gp_a_q;
			else if (ext_idx_q == `DHB_EXT_GP_B)
				rd_d = gp_b_q;
			else if (ext_idx_q == `DHB_EXT_EMUL)
				rd_d = emul_q;
			else if (ext_idx_q == `DHB_EXT_WPROT)
				rd_d = wprot_q;
			else if (ext_idx_q == `DHB_EXT_TRAP_EN)
				rd_d = trap_en_q[7:0];
			else if (ext_idx_q == `DHB_EXT_TRAP_ST)
				rd_d = trap_st_q[7:0];
			else if (ext_idx_q == `DHB_EXT_DEF_VID)
				rd_d = def_vid_q;
		end
	end

	// Pin synchronisers and address latch
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ad_s1 <= 16'h0000;
			ad_s2 <= 16'h0000;
			au_s1 <= 3'h0;
			au_s2 <= 3'h0;
			// Power-down idles low; resetting it high would blank the screen after reset
			pin_s1 <= 9'h0_FF;
			pin_s2 <= 9'h0_FF;
			ad_q <= 16'h0000;
			au_q <= 3'h0;
			bhe_q <= 1'b1;
			high_address_decode_in_q <= 1'b0;
			aen_q <= 1'b1;
		end else if (ce) begin
			ad_s1 <= ad_in;
			ad_s2 <= ad_s1;
			au_s1 <= a_upper;
			au_s2 <= au_s1;
			pin_s1 <= {power_down_pin_one, rfsh_enab, iord_n, iowr_n, memr_n, memw_n,
				aen_mio, high_address_decode_in, bhe_n};
			pin_s2 <= pin_s1;
			// Address, byte-high and memory/IO are held from the address phase
			if (!active) begin
				ad_q <= ad_s2;
				au_q <= au_s2;
				bhe_q <= s_bhe_n;
				high_address_decode_in_q <= s_high_address_decode_in;
				aen_q <= s_aen;
			end
		end
	end

	// Register file and events
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			seq_idx_q <= `DHB_RST_BYTE;
			seq_clk_q <= `DHB_RST_BYTE;
			crt_idx_q <= `DHB_RST_BYTE;
			ext_idx_q <= `DHB_RST_BYTE;
			gp_a_q <= `DHB_RST_BYTE;
			gp_b_q <= `DHB_RST_BYTE;
			emul_q <= `DHB_RST_BYTE;
			wprot_q <= `DHB_RST_BYTE;
			def_vid_q <= `DHB_RST_BYTE;
			setup_port_q <= `DHB_RST_BYTE;
			enable_q <= `DHB_RST_BYTE;
			trap_en_q <= {TRAP_W{1'b0}};
			trap_st_q <= {TRAP_W{1'b0}};
			capt_q <= 16'h0000;
			attr_idx_q <= 4'h0;
			attr_data_q <= 1'b0;
			vsync_q <= 1'b0;
			frame_pend_q <= 1'b0;
			cmd_q <= 1'b0;
			for (i = 0; i < `DHB_LUT_DEPTH; i = i + 1)
				lut_q[i] <= `DHB_RST_LUT;
		end else if (ce) begin
			cmd_q <= active;
			vsync_q <= vsync;
			if (setup_wr && start)
				setup_port_q <= wdat;
			if (frame_end && legacy_mode)
				capt_q <= display_addr;
			if (io_wr) begin
				if (ad_q == `DHB_IO_CFG_ENABLE)
					enable_q <= wdat;
				else if (ad_q == `DHB_IO_SEQ_IDX)
					seq_idx_q <= wdat;
				else if (ad_q == `DHB_IO_SEQ_DAT) begin
					if (seq_idx_q == `DHB_SEQ_CLK_MODE && !wprot_q[`DHB_WP_SEQ])
						seq_clk_q <= wdat;
				end else if (ad_q == `DHB_IO_CRT_IDX) begin
					if (!wprot_q[`DHB_WP_CRT])
						crt_idx_q <= wdat;
				end else if (ad_q == `DHB_IO_ATTR) begin
					// One port alternates between index and data
					attr_data_q <= ~attr_data_q;
					if (!attr_data_q)
						attr_idx_q <= wdat[3:0];
					else if (!wprot_q[`DHB_WP_ATTR])
						lut_q[attr_idx_q] <= wdat[5:0];
				end else if (ad_q == `DHB_IO_EXT_IDX)
					ext_idx_q <= wdat;
				else if (ad_q == `DHB_IO_EXT_DAT) begin
					if (ext_idx_q == `DHB_EXT_GP_A)
						gp_a_q <= wdat;
					else if (ext_idx_q == `DHB_EXT_GP_B)
						gp_b_q <= wdat;
					else if (ext_idx_q == `DHB_EXT_EMUL)
						emul_q <= wdat;
					else if (ext_idx_q == `DHB_EXT_WPROT)
						wprot_q <= wdat;
					else if (ext_idx_q == `DHB_EXT_TRAP_EN)
						trap_en_q <= wdat[TRAP_W-1:0];
					else if (ext_idx_q == `DHB_EXT_DEF_VID)
						def_vid_q <= wdat;
				end
			end
			// Write-one-to-clear; a new enabled condition in the same cycle wins
			if (io_wr && ad_q == `DHB_IO_EXT_DAT && ext_idx_q == `DHB_EXT_TRAP_ST)
				trap_st_q <= (trap_st_q & ~wdat[TRAP_W-1:0]) | (trap_cond & trap_en_q);
			else
				trap_st_q <= trap_st_q | (trap_cond & trap_en_q);
			// Pending frame event; set by the sync edge wins over the clear
			if (vsync && !vsync_q && emul_q[`DHB_EMU_FRAME_EN])
				frame_pend_q <= 1'b1;
			else if (io_wr && ad_q == `DHB_IO_EXT_DAT && ext_idx_q == `DHB_EXT_EMUL &&
				wdat[`DHB_EMU_FRAME_CLR])
				frame_pend_q <= 1'b0;
		end
	end

	// Bus strobes, transceiver control and pin drivers, all registered
	reg [1:0] gp_a_drv, gp_b_drv;
	always @* begin
		gp_a_drv = gp_drive(gp_a_q[1:0], ~|trap_st_q);
		gp_b_drv = gp_drive(gp_b_q[1:0], spare_normal_b);
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			data_out <= `DHB_RST_BYTE;
			data_oe_n <= 1'b1;
			address_phase_enable_n <= 1'b0;
			wide_io_fast_out <= 1'b1;
			wide_io_fast_oe_n <= 1'b1;
			ready_out <= 1'b1;
			ready_oe_n <= 1'b1;
			wide_memory_enable_n <= 1'b1;
			setup_card_select_n <= 1'b1;
			bios_rom_select_n <= 1'b1;
			palette_read_strobe_n <= 1'b1;
			palette_write_strobe_n <= 1'b1;
			irq_out <= 1'b0;
			irq_oe_n <= 1'b1;
			trap_pin_out <= 1'b1;
			trap_pin_oe_n <= 1'b1;
			spare_output_b <= 1'b1;
			spare_output_b_oe_n <= 1'b1;
			video_q <= `DHB_RST_LUT;
			screen_blank_q <= 1'b0;
			hit_q <= 1'b0;
			io_q <= 1'b0;
			wr_q <= 1'b0;
			sw_q <= 1'b0;
		end else if (ce) begin
			address_phase_enable_n <= active;
			if (start) begin
				hit_q <= io_hit | mem_hit;
				io_q <= io_hit;
				wr_q <= is_write;
				if (io_rd)
					data_out <= rd_d;
			end else if (!active) begin
				hit_q <= 1'b0;
			end
			// Switch value is sampled at the start edge, so it is handed out one edge later
			sw_q <= sw_read;
			if (sw_q)
				data_out <= switch_q;
			data_oe_n <= ~(active & hit_q & io_q & ~wr_q);
			// Wait states follow the memory arbiter in memory cycles the card owns; io cycles get none
			ready_out <= ~(mem_busy & ~io_q);
			ready_oe_n <= ~(active & hit_q);
			if (mca_mode) begin
				wide_io_fast_out <= ~(mem_hit & ~emul_q[`DHB_EMU_FAST_OFF]);
				wide_io_fast_oe_n <= 1'b0;
				wide_memory_enable_n <= ~(active & hit_q & ~bhe_q);
				setup_card_select_n <= ~(active & hit_q);
			end else begin
				wide_io_fast_out <= 1'b0;
				wide_io_fast_oe_n <= ~(active & hit_q & io_q);
				wide_memory_enable_n <= ~emul_q[`DHB_EMU_WIDE_MEM];
				setup_card_select_n <= ~(setup_wr & start);
			end
			bios_rom_select_n <= ~(~mca_mode & active & ~is_io & ~is_write & mem_valid &
				rom_win & card_on & ~setup_mode);
			// The state read at 3C7h is answered internally, not by the converter
			palette_read_strobe_n <= ~(active & io_hit & ~is_write & pal_hit &
				(ad_q != `DHB_IO_PAL_STATE) & use_ext_palette);
			palette_write_strobe_n <= ~(active & io_hit & is_write & pal_hit &
				use_ext_palette);
			// PC mode 0 keeps the line floating; mode 1 drives both levels while the frame event is enabled
			if (mca_mode) begin
				irq_out <= 1'b0;
				irq_oe_n <= ~frame_pend_q;
			end else if (emul_q[`DHB_EMU_IRQ_MODE]) begin
				irq_out <= frame_pend_q;
				irq_oe_n <= ~emul_q[`DHB_EMU_FRAME_EN];
			end else begin
				irq_out <= 1'b0;
				irq_oe_n <= 1'b1;
			end
			trap_pin_out <= gp_a_drv[0];
			trap_pin_oe_n <= gp_a_drv[1];
			spare_output_b <= gp_b_drv[0];
			spare_output_b_oe_n <= gp_b_drv[1];
			screen_blank_q <= seq_clk_q[`DHB_SEQ_BLANK_BIT] | s_pwrdn;
			if (!blank_n)
				video_q <= def_vid_q[5:0];
			else if (!panel_mode || emul_q[`DHB_EMU_PANEL_LUT])
				video_q <= lut_q[pixel_index];
			else
				video_q <= {2'b00, pixel_index};
		end
	end
endmodule

// File: dv/dhb_host_bus_chk.sv
// Pin-level assertions for the host bus block
`timescale 1ns/10ps
module dhb_host_bus_chk (
	input wire mclk,
	input wire nrst,
	input wire mca_mode,
	input wire memw_n,
	input wire memr_n,
	input wire iowr_n,
	input wire iord_n,
	input wire power_down_pin_one,
	input wire analog_crt,
	input wire panel_mode,
	input wire data_oe_n,
	input wire address_phase_enable_n,
	input wire wide_io_fast_oe_n,
	input wire ready_oe_n,
	input wire setup_card_select_n,
	input wire bios_rom_select_n,
	input wire palette_read_strobe_n,
	input wire palette_write_strobe_n,
	input wire screen_blank_q,
	input wire use_ext_palette
);
	// Six cycles of history, since the sync stage makes the exact lag fuzzy by one cycle
	reg [5:0] rd_q;
	reg [5:0] wr_q;
	reg [5:0] mr_q;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_q <= 6'h00;
			wr_q <= 6'h00;
			mr_q <= 6'h00;
		end else begin
			rd_q <= {rd_q[4:0], ~iord_n};
			wr_q <= {wr_q[4:0], ~iowr_n};
			mr_q <= {mr_q[4:0], ~memr_n};
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	sequence s_bus_idle;
		(memw_n && memr_n && iowr_n && iord_n && !mca_mode) [*6];
	endsequence
	sequence s_pd_held;
		power_down_pin_one [*6];
	endsequence
	a_address_phase_enable_idle: assert property (s_bus_idle |-> !address_phase_enable_n)
		else $error("address phase output not low on idle bus");
	a_ready_float: assert property (s_bus_idle |-> ready_oe_n)
		else $error("ready driven on idle bus");
	a_iocs_float: assert property (s_bus_idle |-> wide_io_fast_oe_n && data_oe_n)
		else $error("wide select or data driven on idle bus");
	a_palette_read_strobe_cause: assert property (!palette_read_strobe_n |-> rd_q != 6'h00 && $past(use_ext_palette))
		else $error("palette read strobe without io read");
	a_palette_write_strobe_cause: assert property (!palette_write_strobe_n |-> wr_q != 6'h00 && $past(use_ext_palette))
		else $error("palette write strobe without io write");
	a_ext_pal: assert property (use_ext_palette == (analog_crt && !panel_mode))
		else $error("external palette use wrong");
	a_rom_cause: assert property (!bios_rom_select_n |-> !mca_mode && mr_q != 6'h00)
		else $error("rom select without memory read");
	a_setup_pulse: assert property ($fell(setup_card_select_n) && !mca_mode |=> setup_card_select_n)
		else $error("setup port strobe longer than one cycle");
	a_blank_pin: assert property (s_pd_held |-> screen_blank_q)
		else $error("power down pin did not blank");
endmodule
bind dhb_host_bus dhb_host_bus_chk u_chk (.mclk(mclk), .nrst(nrst), .mca_mode(mca_mode),
	.memw_n(memw_n), .memr_n(memr_n), .iowr_n(iowr_n), .iord_n(iord_n),
	.power_down_pin_one(power_down_pin_one), .analog_crt(analog_crt), .panel_mode(panel_mode),
	.data_oe_n(data_oe_n), .address_phase_enable_n(address_phase_enable_n),
	.wide_io_fast_oe_n(wide_io_fast_oe_n), .ready_oe_n(ready_oe_n),
	.setup_card_select_n(setup_card_select_n), .bios_rom_select_n(bios_rom_select_n),
	.palette_read_strobe_n(palette_read_strobe_n), .palette_write_strobe_n(palette_write_strobe_n),
	.screen_blank_q(screen_blank_q), .use_ext_palette(use_ext_palette));

// File: dv/dhb_cpu_model.sv
// Bus master model for both bus modes that runs io and memory cycles against the block
`timescale 1ns/10ps
module dhb_cpu_model (
	input wire mclk,
	input wire mca_mode,
	output reg [15:0] ad_in,
	output reg [2:0] a_upper,
	output reg bhe_n,
	output reg high_address_decode_in,
	output reg aen_mio,
	output reg memw_n,
	output reg memr_n,
	output reg iowr_n,
	output reg iord_n,
	output reg rfsh_enab,
	input wire [7:0] data_out,
	input wire data_oe_n,
	input wire ready_out,
	input wire ready_oe_n,
	input wire wide_io_fast_oe_n,
	input wire bios_rom_select_n,
	input wire palette_read_strobe_n,
	input wire palette_write_strobe_n,
	input wire setup_card_select_n
);
	// Seen low in the last cycle: card select, rom, pal write, pal read, wide select, wait
	reg [5:0] seen;
	initial begin
		seen = 6'h00;
		ad_in = 16'h0000;
		a_upper = 3'h0;
		bhe_n = 1'b1;
		high_address_decode_in = 1'b0;
		aen_mio = 1'b0;
		{memr_n, memw_n, iord_n, iowr_n} = 4'hF;
		rfsh_enab = 1'b1;
	end
	// Kind 0 io write, 1 io read, 2 memory write, 3 memory read
	task cyc(input [1:0] kind, input [15:0] addr, input [7:0] wdat, output [7:0] rdat);
		integer n;
		begin
			seen = 6'h00;
			rdat = 8'h00;
			n = 0;
			ad_in = addr;
			aen_mio = mca_mode & kind[1];
			// Address must sit through the sync depth before the strobe falls
			repeat (4) @(negedge mclk);
			ad_in = kind[0] ? ~addr : {8'h00, wdat};
			// Refresh is marked by the bench on rfsh_enab; the command line falls in refresh cycles too
			if (mca_mode)
				{memr_n, memw_n, iord_n} = {~kind[0], kind[0], 1'b0};
			else
				{memr_n, memw_n, iord_n, iowr_n} = ~(4'h1 << kind);
			// Outputs are looked at on the falling edge, where they have settled
			while (n < 40 && (n < 6 || !(ready_oe_n || ready_out))) begin
				@(negedge mclk);
				n = n + 1;
				seen = seen | {~setup_card_select_n, ~bios_rom_select_n,
					~palette_write_strobe_n, ~palette_read_strobe_n, ~wide_io_fast_oe_n,
					~ready_oe_n & ~ready_out};
				if (!data_oe_n)
					rdat = data_out;
			end
			@(negedge mclk);
			{memr_n, memw_n, iord_n} = 3'h7;
			// In the other bus mode this pin is the setup level, held by the bench
			if (!mca_mode)
				iowr_n = 1'b1;
			// Released bus shows no stale value
			ad_in = ~ad_in;
			repeat (4) @(negedge mclk);
		end
	endtask
endmodule

// File: dv/tb_dhb_host_bus.sv
// Self-checking bench for the host bus block
`timescale 1ns/10ps
module tb_dhb_host_bus;
	reg mclk = 1'b0;
	reg nrst = 1'b0;
	reg mem_busy = 1'b0;
	reg vsync = 1'b0;
	reg frame_end = 1'b0;
	reg legacy_mode = 1'b0;
	reg blank_n = 1'b1;
	reg panel_mode = 1'b0;
	reg analog_crt = 1'b1;
	reg power_down_pin_one = 1'b0;
	reg spare_normal_b = 1'b1;
	reg [15:0] display_addr = 16'h0000;
	reg [7:0] trap_cond = 8'h00;
	reg [3:0] pixel_index = 4'h0;
	wire ce = 1'b1;
	reg mca_mode = 1'b0;
	wire [15:0] ad_in;
	wire [2:0] a_upper;
	wire [7:0] data_out;
	wire [5:0] video_q;
	wire bhe_n, high_address_decode_in, aen_mio, memw_n, memr_n, iowr_n, iord_n, rfsh_enab, data_oe_n;
	wire address_phase_enable_n, wide_io_fast_oe_n, ready_out, ready_oe_n;
	wire wide_memory_enable_n, setup_card_select_n, bios_rom_select_n, palette_read_strobe_n;
	wire palette_write_strobe_n, irq_out, irq_oe_n, trap_pin_out, trap_pin_oe_n;
	wire spare_output_b, spare_output_b_oe_n;
	integer bad_count = 0;
	integer cmp_count = 0;
	integer i;
	reg [7:0] r;
	dhb_host_bus DUT (.mclk, .nrst, .ce, .mca_mode, .ad_in, .a_upper, .bhe_n, .high_address_decode_in, .aen_mio,
		.memw_n, .memr_n, .iowr_n, .iord_n, .rfsh_enab, .power_down_pin_one, .data_out,
		.data_oe_n, .address_phase_enable_n, .wide_io_fast_out(), .wide_io_fast_oe_n,
		.ready_out, .ready_oe_n, .wide_memory_enable_n, .setup_card_select_n,
		.bios_rom_select_n, .palette_read_strobe_n, .palette_write_strobe_n, .irq_out,
		.irq_oe_n, .trap_pin_out, .trap_pin_oe_n, .spare_output_b, .spare_output_b_oe_n,
		.spare_normal_b, .mem_busy, .vsync, .frame_end, .legacy_mode, .display_addr,
		.trap_cond, .blank_n, .pixel_index, .panel_mode, .analog_crt, .video_q,
		.screen_blank_q(), .use_ext_palette());
	dhb_cpu_model cpu (.mclk, .mca_mode, .ad_in, .a_upper, .bhe_n, .high_address_decode_in, .aen_mio, .memw_n,
		.memr_n,
		.iowr_n, .iord_n, .rfsh_enab, .data_out, .data_oe_n, .ready_out, .ready_oe_n,
		.wide_io_fast_oe_n, .bios_rom_select_n, .palette_read_strobe_n,
		.palette_write_strobe_n, .setup_card_select_n);
	initial forever #5 mclk = ~mclk;
	task end_of_test;
		begin
			if (bad_count == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] d);
		cpu.cyc(2'h0, a, d, r);
	endtask
	task rd(input [15:0] a);
		cpu.cyc(2'h1, a, 8'h00, r);
	endtask
	task xw(input [7:0] idx, input [7:0] d);
		begin
			wr(16'h03D6, idx);
			wr(16'h03D7, d);
		end
	endtask
	task xr(input [7:0] idx, input [7:0] exp);
		begin
			wr(16'h03D6, idx);
			rd(16'h03D7);
			chk(r, exp);
		end
	endtask
	// Whole run needs about 1,000 cycles; ten thousand means a hang
	initial begin
		#100000;
		bad_count = bad_count + 1;
		end_of_test;
	end
	initial begin
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		@(negedge mclk);
		chk({data_oe_n, ready_oe_n, wide_io_fast_oe_n, irq_oe_n, address_phase_enable_n,
			bios_rom_select_n, palette_read_strobe_n, palette_write_strobe_n}, 8'hF7);
		wr(16'h46E8, 8'h10);
		chk({7'h00, cpu.seen[5]}, 8'h01);
		wr(16'h0102, 8'h01);
		wr(16'h46E8, 8'h00);
		for (i = 0; i < 2; i = i + 1) begin
			cpu.a_upper = i[0] ? 3'h2 : 3'h5;
			cpu.bhe_n = i[0];
			cpu.high_address_decode_in = !i[0];
			xr(8'h01, i[0] ? 8'h4A : 8'h55);
		end
		cpu.a_upper = 3'h0;
		wr(16'h03C4, 8'h01);
		wr(16'h03C5, 8'h20);
		chk({7'h00, DUT.screen_blank_q}, 8'h01);
		xw(8'h15, 8'h01);
		wr(16'h03C5, 8'h00);
		chk({7'h00, DUT.screen_blank_q}, 8'h01);
		xw(8'h15, 8'h00);
		wr(16'h03C5, 8'h00);
		chk({7'h00, DUT.screen_blank_q}, 8'h00);
		power_down_pin_one = 1'b1;
		repeat (6) @(negedge mclk);
		chk({7'h00, DUT.screen_blank_q}, 8'h01);
		power_down_pin_one = 1'b0;
		legacy_mode = 1'b1;
		display_addr = 16'hA5C3;
		frame_end = 1'b1;
		@(negedge mclk);
		frame_end = 1'b0;
		display_addr = 16'h0000;
		wr(16'h03D4, 8'h10);
		rd(16'h03D5);
		chk(r, 8'hA5);
		wr(16'h03D4, 8'h11);
		rd(16'h03D5);
		chk(r, 8'hC3);
		for (i = 6; i < 10; i = i + 1) begin
			wr(16'h03C0 | i[15:0], 8'h00);
			chk({7'h00, cpu.seen[3]}, 8'h01);
			rd(16'h03C0 | i[15:0]);
			chk({7'h00, cpu.seen[2]}, {7'h00, i != 7});
		end
		chk({7'h00, cpu.seen[1]}, 8'h01);
		analog_crt = 1'b0;
		wr(16'h03C8, 8'h00);
		chk({7'h00, cpu.seen[3]}, 8'h00);
		analog_crt = 1'b1;
		for (i = 0; i < 2; i = i + 1) begin
			wr(16'h03C0, i[0] ? 8'h0F : 8'h05);
			wr(16'h03C0, i[0] ? 8'h3F : 8'h15);
			pixel_index = i[0] ? 4'hF : 4'h5;
			repeat (3) @(negedge mclk);
			chk({2'h0, video_q}, i[0] ? 8'h3F : 8'h15);
		end
		xw(8'h2B, 8'h2A);
		blank_n = 1'b0;
		repeat (3) @(negedge mclk);
		chk({2'h0, video_q}, 8'h2A);
		blank_n = 1'b1;
		// Normal level low, so the normal setting differs from forced high
		spare_normal_b = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			xw(8'h09, i[7:0]);
			chk(i == 1 ? {7'h00, spare_output_b_oe_n} : {6'h00, spare_output_b_oe_n, spare_output_b},
				{7'h00, i[0]});
		end
		xw(8'h16, 8'h01);
		trap_cond = 8'h03;
		repeat (2) @(negedge mclk);
		trap_cond = 8'h00;
		xr(8'h17, 8'h01);
		chk({6'h00, trap_pin_oe_n, trap_pin_out}, 8'h00);
		xw(8'h17, 8'h01);
		xr(8'h17, 8'h00);
		xw(8'h14, 8'h81);
		vsync = 1'b1;
		repeat (3) @(negedge mclk);
		vsync = 1'b0;
		chk({6'h00, irq_oe_n, irq_out}, 8'h01);
		chk({7'h00, wide_memory_enable_n}, 8'h01);
		xw(8'h14, 8'h83);
		chk({6'h00, irq_oe_n, irq_out}, 8'h00);
		xw(8'h14, 8'h20);
		chk({6'h00, irq_oe_n, wide_memory_enable_n}, 8'h02);
		cpu.high_address_decode_in = 1'b1;
		cpu.a_upper = 3'h2;
		mem_busy = 1'b1;
		fork
			cpu.cyc(2'h2, 16'h0000, 8'h5A, r);
			begin
				repeat (12) @(negedge mclk);
				mem_busy = 1'b0;
			end
		join
		chk({7'h00, cpu.seen[0]}, 8'h01);
		cpu.a_upper = 3'h4;
		// Read C0000, read C8000, write C0000, read C0000 during refresh
		for (i = 0; i < 4; i = i + 1) begin
			cpu.rfsh_enab = i != 3;
			cpu.cyc(i == 2 ? 2'h2 : 2'h3, i == 1 ? 16'h8000 : 16'h0000, 8'h00, r);
			chk({7'h00, cpu.seen[4]}, {7'h00, i == 0});
		end
		// Other bus pin meanings: setup level on the write pin, command on the read pin
		cpu.rfsh_enab = 1'b1;
		cpu.a_upper = 3'h2;
		mca_mode = 1'b1;
		cpu.iowr_n = 1'b0;
		cpu.cyc(2'h1, 16'h0102, 8'h00, r);
		chk(r, 8'h01);
		chk({7'h00, cpu.seen[5]}, 8'h01);
		cpu.cyc(2'h1, 16'h03D6, 8'h00, r);
		chk({7'h00, cpu.seen[5]}, 8'h00);
		cpu.iowr_n = 1'b1;
		cpu.cyc(2'h1, 16'h03D6, 8'h00, r);
		chk(r, 8'h14);
		for (i = 0; i < 2; i = i + 1) begin
			cpu.rfsh_enab = !i[0];
			cpu.cyc(2'h3, 16'h0000, 8'h00, r);
			chk({7'h00, cpu.seen[5]}, {7'h00, !i[0]});
		end
		end_of_test;
	end
endmodule
